// ### core/cpu_dedicated_registers.sv
// Dedicated register set of the CPU core: pointers, accumulators, status word,
// condition flags, interrupt acceptance and register bank addressing.
// Assumes the execution logic and the software port share ref_clk and srst.
// Operation
// - Program counter is a 16-bit register pointing at the next instruction.
// - Accumulator is 16 bits; byte instructions use only its low byte.
// - Temporary accumulator is the second operand; byte instructions use its low byte.
// - A 16-bit index register modifies operand addresses.
// - A 16-bit extra pointer supplies a memory address.
// - A 16-bit stack pointer marks the current stack position.
// - Status word upper byte is bank pointer, lower byte is flag byte.
// - Half-carry set on carry or borrow between bits 3 and 4.
// - Interrupts accepted only while enable flag is 1; reset clears it.
// - Interrupt serviced only if its level outranks the level field.
// - Negative flag copies the result's most significant bit.
// - Zero flag set for zero result, cleared otherwise.
// - Overflow flag set on two's complement overflow, else cleared; decimal adjust here keeps it unchanged.
// - Carry flag set on carry or borrow out of bit 7; word operations here take it from bit 15 instead.
// - Shifts load the carry flag with the shifted-out bit.
// - Byte registers, eight per bank, 32 banks, chosen by bank pointer.
// - Usable banks limited by implemented RAM size.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "cpu_regs_map.svh"
module cpu_dedicated_registers
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire cpu_regs_pkg::exec_ctrl_type exec_ctrl,
   input wire logic irq_pending,
   input wire logic [1:0] irq_request_level,
   output logic irq_accept,
   input wire logic [2:0] gpr_index,
   output logic [15:0] gpr_addr,
   output logic gpr_bank_ok,
   output logic [15:0] instruction_pointer,
   output logic [15:0] acc,
   output logic [15:0] temp_acc,
   output logic [15:0] offset_reg,
   output logic [15:0] aux_memory_ptr,
   output logic [15:0] stack_top_ptr,
   output logic [15:0] status_word
);

   // Maps a port offset to a register select; shared by reads and writes
   function automatic cpu_regs_pkg::reg_sel_type decode_offset(input logic [3:0] ofs);
      case (ofs)
         `OFS_INSTR_PTR: decode_offset = cpu_regs_pkg::SEL_INSTR_PTR;
         `OFS_ACC: decode_offset = cpu_regs_pkg::SEL_ACC;
         `OFS_TEMP_ACC: decode_offset = cpu_regs_pkg::SEL_TEMP_ACC;
         `OFS_OFFSET_REG: decode_offset = cpu_regs_pkg::SEL_OFFSET_REG;
         `OFS_AUX_PTR: decode_offset = cpu_regs_pkg::SEL_AUX_PTR;
         `OFS_STACK_PTR: decode_offset = cpu_regs_pkg::SEL_STACK_PTR;
         `OFS_STATUS_WORD: decode_offset = cpu_regs_pkg::SEL_STATUS_WORD;
         default: decode_offset = cpu_regs_pkg::SEL_NONE;
      endcase
   endfunction

   // Data registers indexed 0..4: acc, temp, index, extra, stack
   function automatic logic [2:0] data_index(input cpu_regs_pkg::reg_sel_type sel);
      case (sel)
         cpu_regs_pkg::SEL_ACC: data_index = 3'h0;
         cpu_regs_pkg::SEL_TEMP_ACC: data_index = 3'h1;
         cpu_regs_pkg::SEL_OFFSET_REG: data_index = 3'h2;
         cpu_regs_pkg::SEL_AUX_PTR: data_index = 3'h3;
         cpu_regs_pkg::SEL_STACK_PTR: data_index = 3'h4;
         default: data_index = 3'h7;
      endcase
   endfunction

   logic [15:0] pc;
   logic [15:0] next_pc;
   logic [15:0] data_reg [0:4];
   logic [15:0] next_data_reg [0:4];
   logic [7:0] bank_select_ptr;
   logic [7:0] next_bank_select_ptr;
   cpu_regs_pkg::cond_flags_type cond_flags_byte;
   cpu_regs_pkg::cond_flags_type next_cond_flags_byte;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   cpu_regs_pkg::alu_result_type alu_out;
   cpu_regs_pkg::reg_sel_type bus_sel;
   logic [2:0] bus_idx;
   logic [2:0] exec_idx;
   logic [4:0] bank_num;
   logic [15:0] read_mux;

   cond_flag_unit i_cond_flag_unit
   (
      .op(exec_ctrl.alu_op),
      .wide(exec_ctrl.alu_wide),
      .acc(data_reg[0]),
      .temp(data_reg[1]),
      .flags_in(cond_flags_byte),
      .result(alu_out)
   );

   assign bus_sel = decode_offset(reg_addr);
   assign bus_idx = data_index(bus_sel);
   assign exec_idx = data_index(exec_ctrl.wr_sel);

   // Bank pointer top five bits pick one of 32 banks of eight bytes
   assign bank_num = bank_select_ptr[`BANK_SEL_LSB +: 5];
   assign gpr_addr = `BANK_BASE_ADDR + {8'h00, bank_num, gpr_index};
   assign gpr_bank_ok = ({1'b0, bank_num} < `BANK_COUNT_RAM);

   // Lower code outranks higher; level field 11 still admits levels zero, one and two
   assign irq_accept = cond_flags_byte.i && irq_pending
      && (irq_request_level < cond_flags_byte.irq_priority_field);

   always_comb
   begin
      case (bus_sel)
         cpu_regs_pkg::SEL_INSTR_PTR: read_mux = pc;
         cpu_regs_pkg::SEL_STATUS_WORD: read_mux = {bank_select_ptr, cond_flags_byte};
         cpu_regs_pkg::SEL_NONE:
         begin
            read_mux = 16'h0000;
            if (reg_addr == `OFS_CORE_STATE)
            begin
               read_mux[`STATE_ACCEPT_BIT] = irq_accept;
               read_mux[`STATE_BANK_OK_BIT] = gpr_bank_ok;
            end
         end
         default: read_mux = data_reg[bus_idx];
      endcase
   end

   always_comb
   begin
      next_pc = pc;
      next_bank_select_ptr = bank_select_ptr;
      next_cond_flags_byte = cond_flags_byte;
      for (int k = 0; k < 5; k++)
         next_data_reg[k] = data_reg[k];
      next_rdata = reg_rd ? read_mux : 16'h0000;

      // Software port first, so the execution side wins a same-cycle clash
      if (reg_wr)
      begin
         case (bus_sel)
            cpu_regs_pkg::SEL_INSTR_PTR: next_pc = reg_wdata;
            cpu_regs_pkg::SEL_STATUS_WORD:
            begin
               next_bank_select_ptr = reg_wdata[15:8];
               next_cond_flags_byte = reg_wdata[7:0];
            end
            cpu_regs_pkg::SEL_NONE: next_pc = pc;
            default: next_data_reg[bus_idx] = reg_wdata;
         endcase
      end

      if (exec_ctrl.pc_load)
         next_pc = exec_ctrl.pc_value;
      else if (exec_ctrl.pc_inc)
         next_pc = pc + 16'h0001;

      // Stack pushes move down by one byte, pops move up
      case (exec_ctrl.stack_move)
         cpu_regs_pkg::STACK_PUSH: next_data_reg[4] = data_reg[4] - 16'h0001;
         cpu_regs_pkg::STACK_POP: next_data_reg[4] = data_reg[4] + 16'h0001;
         default: next_data_reg[4] = next_data_reg[4];
      endcase

      if (exec_ctrl.wr_en)
      begin
         case (exec_ctrl.wr_sel)
            cpu_regs_pkg::SEL_INSTR_PTR: next_pc = exec_ctrl.wr_data;
            cpu_regs_pkg::SEL_STATUS_WORD:
            begin
               next_bank_select_ptr = exec_ctrl.wr_data[15:8];
               next_cond_flags_byte = exec_ctrl.wr_data[7:0];
            end
            cpu_regs_pkg::SEL_NONE: next_pc = next_pc;
            default: next_data_reg[exec_idx] = exec_ctrl.wr_data;
         endcase
      end

      // Result lands in the accumulator; byte results leave its high byte alone
      if (exec_ctrl.alu_go)
      begin
         if (exec_ctrl.alu_wide)
            next_data_reg[0] = alu_out.value;
         else
            next_data_reg[0] = {data_reg[0][15:8], alu_out.value[7:0]};
         next_cond_flags_byte = alu_out.flags;
      end
   end

   // Data registers carry no reset, so a reset never disturbs their contents
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         for (int k = 0; k < 5; k++)
            data_reg[k] <= next_data_reg[k];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pc <= `RST_INSTR_PTR;
         bank_select_ptr <= 8'h00;
         cond_flags_byte <= 8'h00;
         cond_flags_byte.i <= 1'b0;
         cond_flags_byte.irq_priority_field <= `RST_IRQ_PRIORITY;
         rdata <= 16'h0000;
      end
      else if (clk_en)
      begin
         pc <= next_pc;
         bank_select_ptr <= next_bank_select_ptr;
         cond_flags_byte <= next_cond_flags_byte;
         rdata <= next_rdata;
      end
   end

   assign reg_rdata = rdata;
   assign instruction_pointer = pc;
   assign acc = data_reg[0];
   assign temp_acc = data_reg[1];
   assign offset_reg = data_reg[2];
   assign aux_memory_ptr = data_reg[3];
   assign stack_top_ptr = data_reg[4];
   assign status_word = {bank_select_ptr, cond_flags_byte};

endmodule

// ### core/cpu_regs_map.svh
// Offsets, field positions, reset values and fixed sizes of the dedicated register set.
// Included by the register file and by its monitor; holds definitions only.
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

// Word offsets on the software register port
`define OFS_INSTR_PTR 4'h0
`define OFS_ACC 4'h1
`define OFS_TEMP_ACC 4'h2
`define OFS_OFFSET_REG 4'h3
`define OFS_AUX_PTR 4'h4
`define OFS_STACK_PTR 4'h5
`define OFS_STATUS_WORD 4'h6
`define OFS_CORE_STATE 4'h7

// Reset values
`define RST_INSTR_PTR 16'hfffd
`define RST_IRQ_PRIORITY 2'h3

// Condition flag byte layout
`define CCR_H_BIT 7
`define CCR_I_BIT 6
`define CCR_IL_HI_BIT 5
`define CCR_IL_LO_BIT 4
`define CCR_N_BIT 3
`define CCR_Z_BIT 2
`define CCR_V_BIT 1
`define CCR_C_BIT 0

// Register banks in data memory
`define BANK_BASE_ADDR 16'h0100
`define BANK_COUNT_MAX 6'h20
`define BANK_COUNT_RAM 6'h20
`define BANK_SEL_LSB 3

// Core state word fields
`define STATE_ACCEPT_BIT 0
`define STATE_BANK_OK_BIT 1

`endif

// ### core/cpu_regs_pkg.sv
// Types shared by the dedicated register set and its flag unit.
// Field layout of the flag byte matches the positions in cpu_regs_map.svh.
package cpu_regs_pkg;

   typedef enum logic [2:0] {
      SEL_INSTR_PTR,
      SEL_ACC,
      SEL_TEMP_ACC,
      SEL_OFFSET_REG,
      SEL_AUX_PTR,
      SEL_STACK_PTR,
      SEL_STATUS_WORD,
      SEL_NONE
   } reg_sel_type;

   typedef enum logic [3:0] {
      OP_ADD,
      OP_ADDC,
      OP_SUB,
      OP_SUBC,
      OP_AND,
      OP_OR,
      OP_XOR,
      OP_SHL,
      OP_SHR,
      OP_DEC_ADJ
   } alu_op_type;

   typedef enum logic [1:0] {
      STACK_HOLD,
      STACK_PUSH,
      STACK_POP
   } stack_move_type;

   typedef struct packed {
      logic h;
      logic i;
      logic [1:0] irq_priority_field;
      logic n;
      logic z;
      logic v;
      logic c;
   } cond_flags_type;

   typedef struct packed {
      logic pc_inc;
      logic pc_load;
      logic [15:0] pc_value;
      stack_move_type stack_move;
      logic wr_en;
      reg_sel_type wr_sel;
      logic [15:0] wr_data;
      logic alu_go;
      alu_op_type alu_op;
      logic alu_wide;
   } exec_ctrl_type;

   typedef struct packed {
      logic [15:0] value;
      cond_flags_type flags;
   } alu_result_type;

endpackage

// ### core/cond_flag_unit.sv
// Arithmetic, logic and shift unit that produces a result and the new flag byte.
// Assumes operands come straight from the accumulator and temporary accumulator.
`timescale 1ns/100ps
module cond_flag_unit
(
   input wire cpu_regs_pkg::alu_op_type op,
   input wire logic wide,
   input wire logic [15:0] acc,
   input wire logic [15:0] temp,
   input wire cpu_regs_pkg::cond_flags_type flags_in,
   output cpu_regs_pkg::alu_result_type result
);

   logic [16:0] sum;
   logic [4:0] nib;
   logic [15:0] val;
   logic [7:0] adj;
   logic cin;
   logic sub;
   logic msb_a;
   logic msb_b;
   logic msb_r;
   cpu_regs_pkg::cond_flags_type f;

   always_comb
   begin
      f = flags_in;
      cin = (op == cpu_regs_pkg::OP_ADDC || op == cpu_regs_pkg::OP_SUBC) ? flags_in.c : 1'b0;
      sub = (op == cpu_regs_pkg::OP_SUB || op == cpu_regs_pkg::OP_SUBC);
      // Narrow ops see only the low bytes
      if (wide)
      begin
         sum = sub ? ({1'b0, acc} - {1'b0, temp} - {16'h0000, cin})
                   : ({1'b0, acc} + {1'b0, temp} + {16'h0000, cin});
      end
      else
      begin
         sum = sub ? ({9'h000, acc[7:0]} - {9'h000, temp[7:0]} - {16'h0000, cin})
                   : ({9'h000, acc[7:0]} + {9'h000, temp[7:0]} + {16'h0000, cin});
      end
      nib = sub ? ({1'b0, acc[3:0]} - {1'b0, temp[3:0]} - {4'h0, cin})
                : ({1'b0, acc[3:0]} + {1'b0, temp[3:0]} + {4'h0, cin});
      msb_a = wide ? acc[15] : acc[7];
      msb_b = wide ? temp[15] : temp[7];
      adj = 8'h00;
      val = sum[15:0];
      case (op)
         cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADDC, cpu_regs_pkg::OP_SUB,
         cpu_regs_pkg::OP_SUBC:
         begin
            val = wide ? sum[15:0] : {8'h00, sum[7:0]};
            f.h = nib[4];
            f.c = wide ? sum[16] : sum[8];
         end
         cpu_regs_pkg::OP_AND: val = wide ? (acc & temp) : {8'h00, acc[7:0] & temp[7:0]};
         cpu_regs_pkg::OP_OR: val = wide ? (acc | temp) : {8'h00, acc[7:0] | temp[7:0]};
         cpu_regs_pkg::OP_XOR: val = wide ? (acc ^ temp) : {8'h00, acc[7:0] ^ temp[7:0]};
         cpu_regs_pkg::OP_SHL:
         begin
            val = wide ? {acc[14:0], 1'b0} : {8'h00, acc[6:0], 1'b0};
            f.c = msb_a;
         end
         cpu_regs_pkg::OP_SHR:
         begin
            val = wide ? {1'b0, acc[15:1]} : {9'h000, acc[7:1]};
            f.c = acc[0];
         end
         cpu_regs_pkg::OP_DEC_ADJ:
         begin
            // Decimal correction after a byte add, driven by the half-carry
            if (flags_in.h || acc[3:0] > 4'h9)
               adj[3:0] = 4'h6;
            if (flags_in.c || acc[7:0] > 8'h99)
               adj[7:4] = 4'h6;
            val = {8'h00, acc[7:0] + adj};
            f.c = flags_in.c || (acc[7:0] > 8'h99);
         end
         default: val = acc;
      endcase
      msb_r = wide ? val[15] : val[7];
      f.n = msb_r;
      f.z = wide ? (val == 16'h0000) : (val[7:0] == 8'h00);
      case (op)
         cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADDC:
            f.v = (msb_a == msb_b) && (msb_r != msb_a);
         cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SUBC:
            f.v = (msb_a != msb_b) && (msb_r != msb_a);
         cpu_regs_pkg::OP_DEC_ADJ: f.v = flags_in.v;
         default: f.v = 1'b0;
      endcase
      result.value = val;
      result.flags = f;
   end

endmodule

// ### tb/cpu_dedicated_registers_monitor.sv
// Concurrent checks on the ports of the dedicated register set.
// Assumes a single clock ref_clk and the synchronous reset srst.
`timescale 1ns/100ps
`include "cpu_regs_map.svh"
module cpu_dedicated_registers_monitor
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire cpu_regs_pkg::exec_ctrl_type exec_ctrl,
   input wire logic irq_pending,
   input wire logic [1:0] irq_request_level,
   input wire logic irq_accept,
   input wire logic [2:0] gpr_index,
   input wire logic [15:0] gpr_addr,
   input wire logic gpr_bank_ok,
   input wire logic [15:0] instruction_pointer,
   input wire logic [15:0] acc,
   input wire logic [15:0] temp_acc,
   input wire logic [15:0] offset_reg,
   input wire logic [15:0] aux_memory_ptr,
   input wire logic [15:0] stack_top_ptr,
   input wire logic [15:0] status_word
);
   default clocking dc @(posedge ref_clk);
   endclocking
   sequence s_read_acc;
      clk_en && reg_rd && reg_addr == `OFS_ACC;
   endsequence
   // Every op sets N and Z from its result, but only arithmetic is watched here
   sequence s_arith;
      clk_en && exec_ctrl.alu_go && exec_ctrl.alu_op inside {cpu_regs_pkg::OP_ADD,
         cpu_regs_pkg::OP_ADDC, cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SUBC};
   endsequence
   property p_reset_pc;
      srst |=> instruction_pointer == `RST_INSTR_PTR;
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("pc reset value wrong");
   property p_reset_status;
      srst |=> status_word == 16'h0030;
   endproperty
   a_reset_status: assert property (p_reset_status) else $error("status reset wrong");
   property p_irq_enable;
      disable iff (srst) !status_word[`CCR_I_BIT] |-> !irq_accept;
   endproperty
   a_irq_enable: assert property (p_irq_enable) else $error("accept while disabled");
   property p_irq_level;
      disable iff (srst) irq_accept == (status_word[`CCR_I_BIT] && irq_pending
         && irq_request_level < status_word[`CCR_IL_HI_BIT:`CCR_IL_LO_BIT]);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("accept level wrong");
   property p_bank_addr;
      disable iff (srst) gpr_addr == `BANK_BASE_ADDR + {8'h00, status_word[15:11], gpr_index};
   endproperty
   a_bank_addr: assert property (p_bank_addr) else $error("bank address wrong");
   property p_bank_ok;
      disable iff (srst) gpr_bank_ok == ({1'b0, status_word[15:11]} < `BANK_COUNT_RAM);
   endproperty
   a_bank_ok: assert property (p_bank_ok) else $error("bank ok wrong");
   property p_pc_inc;
      disable iff (srst) clk_en && exec_ctrl.pc_inc && !exec_ctrl.pc_load && !(exec_ctrl.wr_en
         && exec_ctrl.wr_sel == cpu_regs_pkg::SEL_INSTR_PTR)
         |=> instruction_pointer == $past(instruction_pointer) + 16'h1;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc did not step");
   property p_push;
      disable iff (srst) clk_en && exec_ctrl.stack_move == cpu_regs_pkg::STACK_PUSH
         && !(exec_ctrl.wr_en && exec_ctrl.wr_sel == cpu_regs_pkg::SEL_STACK_PTR)
         && !(reg_wr && reg_addr == `OFS_STACK_PTR)
         |=> stack_top_ptr == $past(stack_top_ptr) - 16'h1;
   endproperty
   a_push: assert property (p_push) else $error("push did not step");
   property p_read_acc;
      disable iff (srst) s_read_acc |=> reg_rdata == $past(acc);
   endproperty
   a_read_acc: assert property (p_read_acc) else $error("acc read wrong");
   property p_zero;
      disable iff (srst) s_arith |=> status_word[`CCR_Z_BIT] ==
         ($past(exec_ctrl.alu_wide) ? acc == 16'h0000 : acc[7:0] == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_neg;
      disable iff (srst) s_arith |=> status_word[`CCR_N_BIT] ==
         ($past(exec_ctrl.alu_wide) ? acc[15] : acc[7]);
   endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong");
endmodule
bind cpu_dedicated_registers cpu_dedicated_registers_monitor i_cpu_dedicated_registers_monitor
(
   .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .exec_ctrl(exec_ctrl), .irq_pending(irq_pending), .irq_request_level(irq_request_level),
   .irq_accept(irq_accept), .gpr_index(gpr_index), .gpr_addr(gpr_addr),
   .gpr_bank_ok(gpr_bank_ok), .instruction_pointer(instruction_pointer), .acc(acc),
   .temp_acc(temp_acc), .offset_reg(offset_reg), .aux_memory_ptr(aux_memory_ptr),
   .stack_top_ptr(stack_top_ptr), .status_word(status_word)
);

// ### tb/cpu_dedicated_registers_test.sv
// Self-checking bench for the dedicated register set.
// Drives the register port and execution port; expected read values are queued and compared.
`timescale 1ns/100ps
module cpu_dedicated_registers_test;
   logic ref_clk, srst, clk_en, reg_wr, reg_rd, irq_pending, irq_accept, gpr_bank_ok, rd_seen;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, gpr_addr, ip, acc, tacc, ofs, aux, stk, sw;
   logic [1:0] irq_request_level;
   logic [2:0] gpr_index;
   cpu_regs_pkg::exec_ctrl_type exec_ctrl, c;
   logic [15:0] exp_q[$];
   logic [15:0] v;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   cpu_regs_pkg::alu_op_type ops[15] = '{cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADD,
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SHL, cpu_regs_pkg::OP_SHR,
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_ADDC, cpu_regs_pkg::OP_SUBC,
      cpu_regs_pkg::OP_AND, cpu_regs_pkg::OP_XOR, cpu_regs_pkg::OP_OR,
      cpu_regs_pkg::OP_DEC_ADJ, cpu_regs_pkg::OP_DEC_ADJ};
   logic wide[15] = '{0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
   logic [15:0] opa[15] = '{16'h1208, 16'h127f, 16'h34ff, 16'h0000, 16'h0081, 16'h0003,
      16'h00ff, 16'h0080, 16'h0005, 16'h0010, 16'hab3c, 16'h0055, 16'h0001, 16'h0013,
      16'h00a0};
   logic [15:0] opt[15] = '{16'h0008, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
      16'h0001, 16'h0001, 16'h0003, 16'h0001, 16'h00f0, 16'h0055, 16'h0080, 16'h0000,
      16'h0000};
   logic [15:0] res[15] = '{16'h1210, 16'h1280, 16'h3400, 16'h00ff, 16'h0002, 16'h0001,
      16'h0100, 16'h007f, 16'h0009, 16'h000e, 16'hab30, 16'h0000, 16'h0081, 16'h0019,
      16'h0000};
   logic [7:0] flg[15] = '{8'hb0, 8'hba, 8'hb5, 8'hb9, 8'h31, 8'h31, 8'hb0, 8'hb2, 8'h30,
      8'hb0, 8'h31, 8'hb5, 8'h38, 8'hb0, 8'h35};
   // Flag byte loaded before each operation; carry and half-carry feed some ops
   logic [7:0] fin[15] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h31,
      8'h31, 8'h31, 8'hb3, 8'h30, 8'hb0, 8'h30};

   cpu_dedicated_registers i_cpu_dedicated_registers
   (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .exec_ctrl(exec_ctrl), .irq_pending(irq_pending), .irq_request_level(irq_request_level),
      .irq_accept(irq_accept), .gpr_index(gpr_index), .gpr_addr(gpr_addr),
      .gpr_bank_ok(gpr_bank_ok), .instruction_pointer(ip), .acc(acc), .temp_acc(tacc),
      .offset_reg(ofs), .aux_memory_ptr(aux), .stack_top_ptr(stk), .status_word(sw)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task check(input logic [15:0] seen, input logic [15:0] expd);
      samples_checked++;
      if (seen !== expd)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask

   task stop_test;
      $display("Counts: mismatches=%0d compares=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Expected value is queued as the strobe is raised
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   task run(input cpu_regs_pkg::exec_ctrl_type x);
      @(posedge ref_clk);
      exec_ctrl <= x;
      @(posedge ref_clk);
      exec_ctrl <= '0;
   endtask

   always @(posedge ref_clk)
      rd_seen <= reg_rd & clk_en & ~srst;

   // Read data stands for one cycle only, so it is taken mid-cycle
   always @(negedge ref_clk)
      if (rd_seen && exp_q.size() > 0)
         check(reg_rdata, exp_q.pop_front());

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      exec_ctrl = '0;
      irq_pending = 1'b0;
      irq_request_level = 2'h0;
      gpr_index = 3'h0;
      v = 16'($urandom(65));
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 16'hfffd);
      rd(4'h6, 16'h0030);
      rd(4'h7, 16'h0002);
      rd(4'h9, 16'h0000);
      $display("Test reset values done");
      for (int a = 1; a <= 5; a++)
      begin
         v = 16'($urandom());
         wr(a[3:0], v);
         rd(a[3:0], v);
      end
      wr(4'h0, 16'h1234);
      c = '0;
      c.pc_inc = 1'b1;
      run(c);
      rd(4'h0, 16'h1235);
      wr(4'h5, 16'h0200);
      c = '0;
      c.stack_move = cpu_regs_pkg::STACK_PUSH;
      run(c);
      rd(4'h5, 16'h01ff);
      c.stack_move = cpu_regs_pkg::STACK_POP;
      run(c);
      rd(4'h5, 16'h0200);
      $display("Test registers done");
      for (int i = 0; i < 15; i++)
      begin
         wr(4'h6, {8'h00, fin[i]});
         wr(4'h1, opa[i]);
         wr(4'h2, opt[i]);
         c = '0;
         c.alu_go = 1'b1;
         c.alu_op = ops[i];
         c.alu_wide = wide[i];
         run(c);
         rd(4'h1, res[i]);
         rd(4'h6, {8'h00, flg[i]});
      end
      $display("Test flags done");
      // Writes and steps while disabled must leave every register frozen
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(4'h1, 16'h5a5a);
      c = '0;
      c.pc_inc = 1'b1;
      run(c);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rd(4'h1, res[14]);
      rd(4'h0, 16'h1235);
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 16'hfffd);
      rd(4'h6, 16'h0030);
      $display("Test enable and reset done");
      wr(4'h6, 16'h2860);
      irq_pending <= 1'b1;
      gpr_index <= 3'h3;
      for (int l = 0; l < 4; l++)
      begin
         @(posedge ref_clk);
         irq_request_level <= l[1:0];
         @(negedge ref_clk);
         check({15'h0, irq_accept}, {15'h0, l < 2});
      end
      check(gpr_addr, 16'h012b);
      @(posedge ref_clk);
      irq_request_level <= 2'h0;
      rd(4'h7, 16'h0003);
      wr(4'h6, 16'h2820);
      @(negedge ref_clk);
      check({15'h0, irq_accept}, 16'h0000);
      wr(4'h6, 16'h2840);
      @(negedge ref_clk);
      check({15'h0, irq_accept}, 16'h0000);
      $display("Test interrupts and banks done");
      repeat (3) @(posedge ref_clk);
      stop_test();
   end
endmodule
